// ### rtl/plp_pkg.sv
package plp_pkg;

    // ------------------------------------------------------------
    // Bus widths and lane count
    // ------------------------------------------------------------
    localparam int LANE_COUNT = 8;
    localparam int RX_BUS_W = 25;
    localparam int TX_BUS_W = 23;
    localparam int CMD_IN_W = 4;
    localparam int CMD_OUT_W = 12;
    localparam int WORD_W = 16;
    localparam int FLAG_W = 2;
    localparam int POWER_W = 2;
    localparam int MARGIN_W = 3;
    localparam int STATUS_W = 3;
    localparam int TRAIN_W = 6;

    // ------------------------------------------------------------
    // Shared output bus layout
    // ------------------------------------------------------------
    localparam int CO_CLK = 0;
    localparam int CO_RATE = 1;
    localparam int CO_DETECT = 2;
    localparam int CO_DEEMPH = 3;
    localparam int CO_MARGIN_LO = 4;

    // ------------------------------------------------------------
    // Lane transmit bus layout
    // ------------------------------------------------------------
    localparam int TX_WORD_LO = 0;
    localparam int TX_FLAG_LO = 16;
    localparam int TX_IDLE = 18;
    localparam int TX_COMPLY = 19;
    localparam int TX_POLARITY = 20;
    localparam int TX_POWER_LO = 21;

    // ------------------------------------------------------------
    // Lane receive bus layout
    // ------------------------------------------------------------
    localparam int RX_WORD_LO = 0;
    localparam int RX_FLAG_LO = 16;
    localparam int RX_IDLE = 18;

    // ------------------------------------------------------------
    // Register map (classic Wishbone, byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LANE_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IDLE = 8'h0c;
    localparam logic [31:0] BAD_READ = 32'hdeadbeef;

    // Control register fields
    localparam int CF_RATE = 0;
    localparam int CF_DETECT = 1;
    localparam int CF_DEEMPH = 2;
    localparam int CF_MARGIN_LO = 4;
    // Lane control fields
    localparam int LF_IDLE = 0;
    localparam int LF_COMPLY = 1;
    localparam int LF_POLARITY = 2;
    localparam int LF_POWER_LO = 4;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LANE_RESET = 32'h0000_0031;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } plp_bus_t;

endpackage

// ### rtl/plp_lane_packer.sv
`timescale 1ns/1ps
// How it works
// - Every one of the eight lanes has its own 25-bit receive input bus and 23-bit transmit output bus.
// - Two shared buses serve all lanes, a 4-bit command input and a 12-bit command output.
// - The 4-bit command input does nothing and the block never reads it.
// - Bit 0 of the shared output carries the interface clock, 125 MHz at first rate and 250 MHz at second.
// - Bit 1 of the shared output selects the rate, zero for first generation and one for second.
// - Shared output bits 2, 3 and 6..4 carry receiver detect, de-emphasis and swing margin; bits 11..7 are unused.
// - Each lane transmit bus carries the data word in 15..0 and the two control flags in 17..16.
// - Each lane transmit bus carries idle at 18, compliance at 19, polarity at 20 and power state at 22..21.
// - Lanes one to seven share the bit layout of lane zero.
// - The interface clock steps from 125 MHz to 250 MHz at second rate and both sides live with it.
module plp_lane_packer
    import plp_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // System side
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link clock from the transceiver side, 250 MHz capable
    input wire logic phyClk,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Internal transmit stream, per lane on the link clock
    input wire logic [LANES*WORD_W-1:0] laneTransmitWord,
    input wire logic [LANES*FLAG_W-1:0] laneTransmitControlFlags,
    // Internal receive stream, per lane on the link clock
    output logic [LANES*WORD_W-1:0] laneReceiveWord,
    output logic [LANES*FLAG_W-1:0] laneReceiveControlFlags,
    output logic [LANES-1:0] laneReceiveIdleFlag,
    // Packed PIPE buses
    input wire logic [LANES*RX_BUS_W-1:0] pipeRxSigs,
    output logic [LANES*TX_BUS_W-1:0] pipeTxSigs,
    input wire logic [CMD_IN_W-1:0] commonCommandsIn,
    output logic [CMD_OUT_W-1:0] commonCommandsOut
);

    // ------------------------------------------------------------
    // Register file on ref_clk
    // ------------------------------------------------------------
    logic [31:0] ctrlReg, next_ctrlReg;
    logic [31:0] laneReg, next_laneReg;
    logic [31:0] next_wbDat;
    logic next_wbAck;
    plp_bus_t busState, next_busState;
    logic [LANES-1:0] idleSync1, idleSync2;
    logic [LANES-1:0] idleSticky, next_idleSticky;

    function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    wire busReq = wb_cyc_i && wb_stb_i && (busState == BUS_IDLE);

    always_comb begin
        next_ctrlReg = ctrlReg;
        next_laneReg = laneReg;
        next_wbDat = wb_dat_o;
        next_wbAck = 1'b0;
        next_busState = BUS_IDLE;
        // Hardware set wins over a software clear in the same cycle
        next_idleSticky = idleSticky;
        if (busReq) begin
            next_wbAck = 1'b1;
            next_busState = BUS_ACK;
            next_wbDat = 32'h0000_0000;
            case (wb_adr_i)
                REG_CTRL: begin
                    if (wb_we_i) begin
                        next_ctrlReg = byteMerge(ctrlReg, wb_dat_i, wb_sel_i);
                    end
                    next_wbDat = ctrlReg;
                end
                REG_LANE_CTRL: begin
                    if (wb_we_i) begin
                        next_laneReg = byteMerge(laneReg, wb_dat_i, wb_sel_i);
                    end
                    next_wbDat = laneReg;
                end
                REG_STATUS: begin
                    next_wbDat = 32'(idleSync2);
                end
                REG_IDLE: begin
                    if (wb_we_i) begin
                        next_idleSticky = idleSticky & ~wb_dat_i[LANES-1:0];
                    end
                    next_wbDat = 32'(idleSticky);
                end
                default: begin
                    next_wbDat = BAD_READ;
                end
            endcase
        end
        next_idleSticky = next_idleSticky | idleSync2;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg <= CTRL_RESET;
            laneReg <= LANE_RESET;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            busState <= BUS_IDLE;
            idleSticky <= '0;
            idleSync1 <= '0;
            idleSync2 <= '0;
        end else begin
            ctrlReg <= next_ctrlReg;
            laneReg <= next_laneReg;
            wb_dat_o <= next_wbDat;
            wb_ack_o <= next_wbAck;
            busState <= next_busState;
            idleSticky <= next_idleSticky;
            idleSync1 <= laneReceiveIdleFlag;
            idleSync2 <= idleSync1;
        end
    end

    // ------------------------------------------------------------
    // Control crossing into the link domain
    // ------------------------------------------------------------
    // Toggle handshake: the held copies stay frozen until the link side has taken them,
    // so a burst of writes can never tear a multi-bit field such as the margin
    logic [31:0] xferCtrl, next_xferCtrl, xferLane, next_xferLane;
    logic reqToggle, next_reqToggle;
    logic takenSync1, takenSync2;
    logic reqSync1, reqSync2, reqTaken, next_reqTaken;
    logic [31:0] ctrlLink, next_ctrlLink, laneLink, next_laneLink;
    logic phyRstSync1, phyRst_n;

    // Writes made while a transfer is in flight are picked up by the next one
    always_comb begin
        next_xferCtrl = xferCtrl;
        next_xferLane = xferLane;
        next_reqToggle = reqToggle;
        if ((reqToggle == takenSync2) && ((xferCtrl != ctrlReg) || (xferLane != laneReg))) begin
            next_xferCtrl = ctrlReg;
            next_xferLane = laneReg;
            next_reqToggle = ~reqToggle;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            xferCtrl <= CTRL_RESET;
            xferLane <= LANE_RESET;
            reqToggle <= 1'b0;
            takenSync1 <= 1'b0;
            takenSync2 <= 1'b0;
        end else begin
            xferCtrl <= next_xferCtrl;
            xferLane <= next_xferLane;
            reqToggle <= next_reqToggle;
            takenSync1 <= reqTaken;
            takenSync2 <= takenSync1;
        end
    end

    always_comb begin
        next_ctrlLink = ctrlLink;
        next_laneLink = laneLink;
        next_reqTaken = reqTaken;
        // The held copies cannot move while the toggles differ
        if (reqSync2 != reqTaken) begin
            next_ctrlLink = xferCtrl;
            next_laneLink = xferLane;
            next_reqTaken = reqSync2;
        end
    end

    always_ff @(posedge phyClk or negedge arst_n) begin
        if (!arst_n) begin
            phyRstSync1 <= 1'b0;
            phyRst_n <= 1'b0;
            reqSync1 <= 1'b0;
            reqSync2 <= 1'b0;
            reqTaken <= 1'b0;
            ctrlLink <= CTRL_RESET;
            laneLink <= LANE_RESET;
        end else begin
            phyRstSync1 <= 1'b1;
            phyRst_n <= phyRstSync1;
            reqSync1 <= reqToggle;
            reqSync2 <= reqSync1;
            reqTaken <= next_reqTaken;
            ctrlLink <= next_ctrlLink;
            laneLink <= next_laneLink;
        end
    end

    // ------------------------------------------------------------
    // Link-side packing
    // ------------------------------------------------------------
    logic [LANES*TX_BUS_W-1:0] txPacked, next_txPacked;
    logic [CMD_OUT_W-1:0] cmdPacked, next_cmdPacked;
    logic [LANES*WORD_W-1:0] rxWordQ, next_rxWordQ;
    logic [LANES*FLAG_W-1:0] rxFlagQ, next_rxFlagQ;
    logic [LANES-1:0] rxIdleQ, next_rxIdleQ;

    always_comb begin
        next_txPacked = '0;
        next_rxWordQ = '0;
        next_rxFlagQ = '0;
        next_rxIdleQ = '0;
        for (int l = 0; l < LANES; l++) begin
            next_txPacked[l*TX_BUS_W + TX_WORD_LO +: WORD_W] = laneTransmitWord[l*WORD_W +: WORD_W];
            next_txPacked[l*TX_BUS_W + TX_FLAG_LO +: FLAG_W] = laneTransmitControlFlags[l*FLAG_W +: FLAG_W];
            next_txPacked[l*TX_BUS_W + TX_IDLE] = laneLink[LF_IDLE];
            next_txPacked[l*TX_BUS_W + TX_COMPLY] = laneLink[LF_COMPLY];
            next_txPacked[l*TX_BUS_W + TX_POLARITY] = laneLink[LF_POLARITY];
            next_txPacked[l*TX_BUS_W + TX_POWER_LO +: POWER_W] = laneLink[LF_POWER_LO +: POWER_W];
            // Receive fields are unpacked; upper bits carry nothing we use
            next_rxWordQ[l*WORD_W +: WORD_W] = pipeRxSigs[l*RX_BUS_W + RX_WORD_LO +: WORD_W];
            next_rxFlagQ[l*FLAG_W +: FLAG_W] = pipeRxSigs[l*RX_BUS_W + RX_FLAG_LO +: FLAG_W];
            next_rxIdleQ[l] = pipeRxSigs[l*RX_BUS_W + RX_IDLE];
        end
        // Command input is never read
        next_cmdPacked = '0;
        next_cmdPacked[CO_RATE] = ctrlLink[CF_RATE];
        next_cmdPacked[CO_DETECT] = ctrlLink[CF_DETECT];
        next_cmdPacked[CO_DEEMPH] = ctrlLink[CF_DEEMPH];
        next_cmdPacked[CO_MARGIN_LO +: MARGIN_W] = ctrlLink[CF_MARGIN_LO +: MARGIN_W];
    end

    always_ff @(posedge phyClk or negedge arst_n) begin
        if (!arst_n) begin
            txPacked <= '0;
            cmdPacked <= '0;
            rxWordQ <= '0;
            rxFlagQ <= '0;
            rxIdleQ <= '0;
        end else if (!phyRst_n) begin
            txPacked <= '0;
            cmdPacked <= '0;
            rxWordQ <= '0;
            rxFlagQ <= '0;
            rxIdleQ <= '0;
        end else begin
            txPacked <= next_txPacked;
            cmdPacked <= next_cmdPacked;
            rxWordQ <= next_rxWordQ;
            rxFlagQ <= next_rxFlagQ;
            rxIdleQ <= next_rxIdleQ;
        end
    end

    // Clock bit is the link clock itself; its frequency follows the rate
    always_comb begin
        commonCommandsOut = cmdPacked;
        commonCommandsOut[CO_CLK] = phyClk;
    end

    assign pipeTxSigs = txPacked;
    assign laneReceiveWord = rxWordQ;
    assign laneReceiveControlFlags = rxFlagQ;
    assign laneReceiveIdleFlag = rxIdleQ;

endmodule

// ### bench/plp_lane_packer_checker.sv
`timescale 1ns/1ps
module plp_lane_packer_checker
    import plp_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic phyClk,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Link side
    input wire logic [LANES*WORD_W-1:0] laneTransmitWord,
    input wire logic [LANES*FLAG_W-1:0] laneTransmitControlFlags,
    input wire logic [LANES*WORD_W-1:0] laneReceiveWord,
    input wire logic [LANES-1:0] laneReceiveIdleFlag,
    input wire logic [LANES*RX_BUS_W-1:0] pipeRxSigs,
    input wire logic [LANES*TX_BUS_W-1:0] pipeTxSigs,
    input wire logic [CMD_OUT_W-1:0] commonCommandsOut
);
    // Link checks wait out the reset synchroniser
    logic [2:0] warm;
    logic [2:0] next_warm;
    always_comb next_warm = (warm == 3'h5) ? warm : warm + 3'h1;
    always_ff @(posedge phyClk or negedge arst_n) begin
        if (!arst_n) warm <= 3'h0;
        else warm <= next_warm;
    end
    sequence s_req;
        $rose(wb_stb_i) && wb_cyc_i;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_wb_answer;
        @(posedge ref_clk) disable iff (!arst_n) s_req |=> s_ack;
    endproperty
    property p_wb_cause;
        @(posedge ref_clk) disable iff (!arst_n) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_pipe_clock;
        @(posedge ref_clk) disable iff (!arst_n) commonCommandsOut[CO_CLK] == phyClk;
    endproperty
    property p_spare_zero;
        @(posedge phyClk) disable iff (!arst_n) commonCommandsOut[11:7] == 5'h00;
    endproperty
    property p_tx_word;
        @(posedge phyClk) disable iff (!arst_n) warm == 3'h5 |-> pipeTxSigs[15:0] == $past(laneTransmitWord[15:0]);
    endproperty
    property p_tx_flags_last;
        @(posedge phyClk) disable iff (!arst_n) warm == 3'h5 |-> pipeTxSigs[(LANES-1)*TX_BUS_W+TX_FLAG_LO +: 2]
            == $past(laneTransmitControlFlags[(LANES-1)*FLAG_W +: 2]);
    endproperty
    property p_rx_word_last;
        @(posedge phyClk) disable iff (!arst_n) warm == 3'h5 |-> laneReceiveWord[(LANES-1)*WORD_W +: 16]
            == $past(pipeRxSigs[(LANES-1)*RX_BUS_W +: 16]);
    endproperty
    property p_rx_idle;
        @(posedge phyClk) disable iff (!arst_n) warm == 3'h5 |-> laneReceiveIdleFlag[0] == $past(pipeRxSigs[RX_IDLE]);
    endproperty
    a_wb_answer: assert property (p_wb_answer) else $error("ack missing or too long");
    a_wb_cause: assert property (p_wb_cause) else $error("ack without request");
    a_pipe_clock: assert property (p_pipe_clock) else $error("clock bit differs from link clock");
    a_spare_zero: assert property (p_spare_zero) else $error("spare output bits not zero");
    a_tx_word: assert property (p_tx_word) else $error("lane 0 transmit word wrong");
    a_tx_flags_last: assert property (p_tx_flags_last) else $error("last lane flags wrong");
    a_rx_word_last: assert property (p_rx_word_last) else $error("last lane receive word wrong");
    a_rx_idle: assert property (p_rx_idle) else $error("lane 0 receive idle wrong");
endmodule
bind plp_lane_packer plp_lane_packer_checker #(.LANES(LANES)) plp_lane_packer_checker_inst (.ref_clk, .arst_n,
    .phyClk, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .laneTransmitWord, .laneTransmitControlFlags, .laneReceiveWord,
    .laneReceiveIdleFlag, .pipeRxSigs, .pipeTxSigs, .commonCommandsOut);

// ### bench/plp_phy_model.sv
`timescale 1ns/1ps
module plp_phy_model
    import plp_pkg::*;
#(
    // First-rate half period; the second rate halves it
    parameter int HALF_NS = 32
) (
    // Link clock and receive buses
    output logic phyClk,
    output logic [LANE_COUNT*RX_BUS_W-1:0] pipeRxSigs,
    // Rate select seen from the core
    input logic rateSel
);
    logic [15:0] base = 16'h0000;
    logic [7:0] idleMask = 8'h00;
    // Far-side status that the core leaves unread
    logic modelReceiveValid = 1'b0;
    logic [2:0] modelReceiveResult = 3'h0;
    logic modelPhyDone = 1'b0;
    logic laneAlignedFlag = 1'b0;
    // Odd start offset keeps link edges off the system clock grid
    initial begin
        phyClk = 1'b0;
        pipeRxSigs = '0;
        #3;
        // Clock follows the rate the core asks for
        forever #((rateSel === 1'b1) ? HALF_NS / 2 : HALF_NS) phyClk = ~phyClk;
    end
    task automatic load(input logic [15:0] b, input logic [7:0] idle);
        @(posedge phyClk);
        base <= b;
        idleMask <= idle;
    endtask
    // Ignored upper bits keep moving so nothing can lean on them
    always @(posedge phyClk) begin
        modelReceiveValid <= ~modelReceiveValid;
        modelReceiveResult <= modelReceiveResult + 3'h1;
        modelPhyDone <= (modelReceiveResult == 3'h7);
        laneAlignedFlag <= ~laneAlignedFlag;
        for (int l = 0; l < LANE_COUNT; l++) begin
            pipeRxSigs[l*RX_BUS_W +: RX_BUS_W] <= {modelPhyDone, modelReceiveResult, modelReceiveValid,
                laneAlignedFlag, idleMask[l], 2'(l), base + 16'(l)};
        end
    end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import plp_pkg::*;
    logic ref_clk, arst_n, phyClk, wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [3:0] wbSel, cmdIn;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [127:0] txWord, rxWord;
    logic [15:0] txFlags, rxFlags;
    logic [7:0] rxIdle;
    logic [199:0] rxSigs;
    logic [183:0] txSigs;
    logic [11:0] cmdOut;
    int nFail = 0;
    int nTests = 0;
    plp_lane_packer plp_lane_packer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .phyClk(phyClk), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .laneTransmitWord(txWord), .laneTransmitControlFlags(txFlags), .laneReceiveWord(rxWord),
        .laneReceiveControlFlags(rxFlags), .laneReceiveIdleFlag(rxIdle), .pipeRxSigs(rxSigs), .pipeTxSigs(txSigs),
        .commonCommandsIn(cmdIn), .commonCommandsOut(cmdOut));
    plp_phy_model plp_phy_model_inst (.phyClk(phyClk), .pipeRxSigs(rxSigs), .rateSel(cmdOut[CO_RATE]));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {2'b11, we, adr, dat, 4'hf};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (wbAck !== 1'b1) begin
            nFail++;
            give_verdict();
        end else begin
            q = wbDatR;
            {wbCyc, wbStb} <= 2'b00;
        end
    endtask
    logic [31:0] ctrlVal [2] = '{32'h53, 32'h04};
    logic [31:0] outVal [2] = '{32'h2b, 32'h04};
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        {arst_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW, txWord, txFlags, cmdIn} = '0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge phyClk);
        wb_cycle(1'b0, REG_CTRL, 32'h0, rd);
        check(rd, CTRL_RESET);
        wb_cycle(1'b0, REG_LANE_CTRL, 32'h0, rd);
        check(rd, LANE_RESET);
        wb_cycle(1'b0, 8'h10, 32'h0, rd);
        check(rd, BAD_READ);
        check(32'(txSigs[5*TX_BUS_W+TX_IDLE +: 5]), 32'h19);
        $display("test reset done");
        cmdIn <= 4'ha;
        for (int i = 0; i < 2; i++) begin
            wb_cycle(1'b1, REG_CTRL, ctrlVal[i], rd);
            repeat (6) @(posedge phyClk);
            check(32'(cmdOut[11:1]), outVal[i]);
            @(posedge phyClk);
            @(posedge ref_clk);
            check(32'(cmdOut[CO_CLK]), 32'h1);
            @(negedge phyClk);
            @(posedge ref_clk);
            check(32'(cmdOut[CO_CLK]), 32'h0);
        end
        $display("test shared bus done");
        wb_cycle(1'b1, REG_LANE_CTRL, 32'h26, rd);
        plp_phy_model_inst.load(16'h8e00, 8'ha5);
        // Lane l carries word c3a0 xor l and flags inverted l
        txWord <= {16'hc3a7, 16'hc3a6, 16'hc3a5, 16'hc3a4, 16'hc3a3, 16'hc3a2, 16'hc3a1, 16'hc3a0};
        txFlags <= 16'h1b1b;
        cmdIn <= 4'h5;
        repeat (4) @(posedge phyClk);
        for (int l = 0; l < 8; l++) begin
            check(32'(txSigs[l*TX_BUS_W +: TX_BUS_W]), {9'h0, 5'h16, ~2'(l), 16'hc3a0 ^ 16'(l)});
            check({13'h0, rxIdle[l], rxFlags[l*2 +: 2], rxWord[l*16 +: 16]}, {13'h0, 1'(8'ha5 >> l), 2'(l),
                16'h8e00 + 16'(l)});
        end
        $display("test lanes done");
        wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
        check(rd, 32'ha5);
        // Clear while the idle flags still stand: the hardware set must win
        wb_cycle(1'b1, REG_IDLE, 32'hff, rd);
        wb_cycle(1'b0, REG_IDLE, 32'h0, rd);
        check(rd, 32'ha5);
        plp_phy_model_inst.load(16'h0000, 8'h00);
        repeat (4) @(posedge phyClk);
        wb_cycle(1'b0, REG_IDLE, 32'h0, rd);
        check(rd, 32'ha5);
        wb_cycle(1'b1, REG_IDLE, 32'hff, rd);
        wb_cycle(1'b0, REG_IDLE, 32'h0, rd);
        check(rd, 32'h0);
        $display("test idle status done");
        give_verdict();
    end
endmodule
